// file: uart_lmc_pkg.sv
// Purpose: shared constants, types and helpers of the serial channel
// Assumes: 3-bit register address, 8-bit data bus
// Notes:   offsets with dlab set overlay the first three slots
package uart_lmc_pkg;

   // register offsets
   localparam logic [2:0] OFF_HOLD       = 3'h0;
   localparam logic [2:0] OFF_IRQ_MASK   = 3'h1;
   localparam logic [2:0] OFF_IRQ_IDENT  = 3'h2;
   localparam logic [2:0] OFF_LINE_FMT   = 3'h3;
   localparam logic [2:0] OFF_MODEM_CTL  = 3'h4;
   localparam logic [2:0] OFF_LINE_STAT  = 3'h5;
   localparam logic [2:0] OFF_MODEM_STAT = 3'h6;
   localparam logic [2:0] OFF_SCRATCH    = 3'h7;
   localparam logic [2:0] OFF_DIV_LO     = 3'h0;
   localparam logic [2:0] OFF_DIV_HI     = 3'h1;
   localparam logic [2:0] OFF_FEATURE    = 3'h2;

   // field positions
   localparam int LF_STOP    = 2;
   localparam int LF_PAR_EN  = 3;
   localparam int LF_EVEN    = 4;
   localparam int LF_FORCE   = 5;
   localparam int LF_BREAK   = 6;
   localparam int LF_DLAB    = 7;
   localparam int MC_DTR     = 0;
   localparam int MC_RTS     = 1;
   localparam int MC_RING    = 2;
   localparam int MC_INT_EN  = 3;
   localparam int MC_LOOP    = 4;
   localparam int IE_RX      = 0;
   localparam int IE_TX      = 1;
   localparam int IE_LS      = 2;
   localparam int IE_MS      = 3;

   // reset values and codes
   localparam logic [7:0] LINE_FMT_RST  = 8'h00;
   localparam logic [7:0] MODEM_CTL_RST = 8'h00;
   localparam logic [7:0] IRQ_MASK_RST  = 8'h00;
   localparam logic [7:0] MODEM_CTL_MSK = 8'h1f;
   localparam logic [7:0] IRQ_MASK_MSK  = 8'h0f;
   localparam logic [3:0] IRQ_ID_NONE   = 4'h1;
   localparam logic [3:0] IRQ_ID_LS     = 4'h6;
   localparam logic [3:0] IRQ_ID_RX     = 4'h4;
   localparam logic [3:0] IRQ_ID_TX     = 4'h2;
   localparam logic [3:0] IRQ_ID_MS     = 4'h0;

   // timing counts in 16x ticks, minimum word length and receive shift length
   localparam logic [3:0] START_CENTER = 4'h7;
   localparam logic [3:0] SAMPLE_LAST  = 4'hf;
   localparam logic [2:0] HALF_LAST    = 3'h7;
   localparam logic [3:0] MIN_WORD     = 4'h5;
   localparam logic [3:0] RX_SH_BITS   = 4'ha;

   // buffer shape
   localparam int         BUF_WIDTH = 8;
   localparam int         BUF_DEPTH = 2;
   localparam logic [1:0] BUF_FULL  = 2'h2;

   typedef struct packed {
      logic       cs_n;
      logic       rd_n;
      logic       wr_n;
      logic [2:0] addr;
      logic [7:0] data;
   } bus_pins_t;

   // bit 0 is clear-to-send, bit 3 carrier detect
   typedef struct packed {
      logic cd_n;
      logic ri_n;
      logic dsr_n;
      logic cts_n;
   } modem_pins_t;

   localparam bus_pins_t BUS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 3'h0, data: 8'h00};

   typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} tx_state_t;
   typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_START = 3'b010, RX_DATA = 3'b100} rx_state_t;

   // data bits per character
   function automatic logic [3:0] word_len(input logic [7:0] fmt);
      return {2'b00, fmt[1:0]} + MIN_WORD;
   endfunction

   // parity bit for masked data
   function automatic logic par_bit(input logic [7:0] d, input logic [7:0] fmt);
      if (fmt[LF_FORCE]) return ~fmt[LF_EVEN];
      return fmt[LF_EVEN] ? ^d : ~^d;
   endfunction

endpackage

// file: tx_pair_buffer.sv
// Purpose: two-entry buffer between host writes and the transmitter
// Assumes: single clock, synchronous reset
// Notes:   head entry always sits in slot 0
`timescale 1ns/1ps
`default_nettype none
module tx_pair_buffer
   import uart_lmc_pkg::*;
(
   // clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 srst_in,
   // filling side
   input  wire logic                 in_valid_in,
   input  wire logic [BUF_WIDTH-1:0] in_data_in,
   output logic                      in_ready_out,
   // draining side
   output logic                      out_valid_out,
   output logic [BUF_WIDTH-1:0]      out_data_out,
   input  wire logic                 out_ready_in
);

   typedef struct packed {
      logic [BUF_DEPTH-1:0][BUF_WIDTH-1:0] mem;
      logic [1:0]                          cnt;
   } buf_state_t;

   buf_state_t s;
   buf_state_t next_s;

   // handshakes from the fill count
   assign in_ready_out  = (s.cnt != BUF_FULL);
   assign out_valid_out = (s.cnt != 2'h0);
   assign out_data_out  = s.mem[0];

   // pop shifts slot 1 down, push lands behind
   always_comb begin
      next_s = s;
      if (out_valid_out && out_ready_in) begin
         next_s.mem[0] = s.mem[1];
         next_s.cnt    = next_s.cnt - 2'h1;
      end
      if (in_valid_in && in_ready_out) begin
         next_s.mem[next_s.cnt[0]] = in_data_in;
         next_s.cnt                = next_s.cnt + 2'h1;
      end
      if (srst_in) begin
         next_s = '0;
      end
   end

   always_ff @(posedge clk_in) begin
      s <= next_s;
   end

endmodule
`default_nettype wire

// file: uart_lmc_channel.sv
// Purpose: control and status logic of one asynchronous serial channel
// Assumes: bus and modem pins are asynchronous and pass two flops
// Notes:   16x tick comes from the divisor latch; divisor 0 stops it
// Summary of operation
// - forced parity: one if even-select clear
// - break bit holds transmit output low unless loop-back
// - top format bit opens divisor latch
// - terminal-ready pin is inverse of bit 0
// - request-to-send pin is inverse of bit 1
// - control bit 3 enables interrupt driver
// - control bit 4 selects local loop-back
// - loop-back: bits 2,3 feed ring, carrier
// - status bit 0 flags waiting character
// - overrun keeps held character, flags bit 1
// - status bit 2 flags parity mismatch
// - status bit 3 flags missing stop bit
// - status bit 4 flags whole-frame break
// - status bit 5 flags empty holding register
// - bit 6 flags transmitter fully empty
// - modem inputs change sets flags, read clears
// - ring flag only on low-to-high edge
// - upper modem status shows inputs or loop
// - scratch byte stores and returns data
// - format bit 3 parity, bit 4 even
// - interrupt priority; ident read clears top unless receive
`timescale 1ns/1ps
`default_nettype none
module uart_lmc_channel
   import uart_lmc_pkg::*;
(
   // clock and reset
   input  wire logic         clk_in,
   input  wire logic         srst_in,
   // host bus pins
   input  wire bus_pins_t    bus_in,
   output logic [7:0]        data_out,
   output logic              data_oe_out,
   output logic              tx_ready_out,
   // serial line and modem pins
   input  wire logic         rx_in,
   output logic              tx_out,
   input  wire modem_pins_t  modem_in,
   output logic              dtr_n_out,
   output logic              rts_n_out,
   // interrupt pin
   output logic              int_out,
   output logic              int_oe_out
);

   typedef struct packed {
      bus_pins_t   bus_s1;
      bus_pins_t   bus_s2;
      bus_pins_t   bus_q;
      logic        rx_s1;
      logic        rx_s2;
      modem_pins_t mdm_s1;
      modem_pins_t mdm_s2;
      logic [7:0]  line_format_control;
      logic [7:0]  modem_line_control;
      logic [7:0]  irq_mask_reg;
      logic [7:0]  dll;
      logic [7:0]  dlm;
      logic [7:0]  efr;
      logic [7:0]  scratch_byte;
      logic [7:0]  rx_holding_reg;
      logic [7:0]  rd_data;
      logic        rd_oe;
      logic        dr;
      logic        oe;
      logic        pe;
      logic        fe;
      logic        bi;
      logic [3:0]  delta;
      logic [3:0]  mprev;
      logic        primed;
      logic        thre_pend;
      logic        empty_q;
      logic [15:0] baud_cnt;
      logic        tick;
      tx_state_t   tx_st;
      logic [11:0] tx_sh;
      logic [4:0]  tx_half;
      logic [2:0]  tx_sub;
      logic        tx_phase;
      logic        txd;
      rx_state_t   rx_st;
      logic [3:0]  rx_cnt;
      logic [3:0]  rx_left;
      logic [9:0]  rx_sh;
      logic        rx_zero;
      logic        rx_armed;
   } ctl_state_t;

   ctl_state_t s;
   ctl_state_t next_s;

   logic        rd_ev;
   logic        wr_ev;
   logic [2:0]  addr;
   logic [3:0]  eff_n;
   logic [3:0]  mchg;
   logic [3:0]  iid;
   logic [7:0]  lsr_val;
   logic        rx_done;
   logic [7:0]  rx_data;
   logic        buf_push;
   logic        buf_take;
   logic        buf_valid;
   logic [7:0]  buf_data;
   logic        ls_p;
   logic        rx_p;
   logic        tx_p;
   logic        ms_p;

   // transmit holding buffer
   tx_pair_buffer u_hold (
      .clk_in        (clk_in),
      .srst_in       (srst_in),
      .in_valid_in   (buf_push),
      .in_data_in    (s.bus_s2.data),
      .in_ready_out  (tx_ready_out),
      .out_valid_out (buf_valid),
      .out_data_out  (buf_data),
      .out_ready_in  (buf_take)
   );

   // modem inputs as seen inside, loop-back substitutes control bits
   assign eff_n = s.modem_line_control[MC_LOOP] ? ~{s.modem_line_control[MC_INT_EN], s.modem_line_control[MC_RING], s.modem_line_control[MC_DTR], s.modem_line_control[MC_RTS]}
                                 : s.mdm_s2;
   assign mchg  = s.primed ? {s.mprev[3] ^ eff_n[3], ~s.mprev[2] & eff_n[2],
                              s.mprev[1:0] ^ eff_n[1:0]} : 4'h0;

   // interrupt sources and priority
   assign ls_p = s.irq_mask_reg[IE_LS] & (s.oe | s.pe | s.fe | s.bi);
   assign rx_p = s.irq_mask_reg[IE_RX] & s.dr;
   assign tx_p = s.irq_mask_reg[IE_TX] & s.thre_pend;
   assign ms_p = s.irq_mask_reg[IE_MS] & (|s.delta);
   assign iid  = ls_p ? IRQ_ID_LS : rx_p ? IRQ_ID_RX : tx_p ? IRQ_ID_TX :
                 ms_p ? IRQ_ID_MS : IRQ_ID_NONE;
   assign lsr_val = {1'b0, ~buf_valid && (s.tx_st == TX_IDLE), ~buf_valid,
                     s.bi, s.fe, s.pe, s.oe, s.dr};

   // pins
   assign data_out    = s.rd_data;
   assign data_oe_out = s.rd_oe;
   assign tx_out      = s.txd;
   assign dtr_n_out   = ~s.modem_line_control[MC_DTR];
   assign rts_n_out   = ~s.modem_line_control[MC_RTS];
   assign int_oe_out  = s.modem_line_control[MC_INT_EN];
   assign int_out     = (iid != IRQ_ID_NONE);

   // next state of the whole channel
   always_comb begin
      logic       rxd;
      logic       pen;
      logic [3:0] wl;
      logic [3:0] rx_n;
      logic [9:0] fr;
      logic [7:0] msk;
      logic [4:0] nb;
      next_s   = s;
      rxd      = 1'b1;
      pen      = s.line_format_control[LF_PAR_EN];
      wl       = word_len(s.line_format_control);
      rx_n     = wl + {3'h0, pen} + 4'h1;
      fr       = 10'h000;
      msk      = 8'hff >> (4'h8 - wl);
      nb       = 5'h0;
      rx_done  = 1'b0;
      rx_data  = 8'h00;
      buf_take = 1'b0;
      buf_push = 1'b0;
      // pin synchronisers
      next_s.bus_s1 = bus_in;
      next_s.bus_s2 = s.bus_s1;
      next_s.bus_q  = s.bus_s2;
      next_s.rx_s1  = rx_in;
      next_s.rx_s2  = s.rx_s1;
      next_s.mdm_s1 = modem_in;
      next_s.mdm_s2 = s.mdm_s1;
      addr  = s.bus_s2.addr;
      rd_ev = ~s.bus_s2.cs_n & ~s.bus_s2.rd_n & ~(~s.bus_q.cs_n & ~s.bus_q.rd_n);
      wr_ev = ~s.bus_s2.cs_n & ~s.bus_s2.wr_n & ~(~s.bus_q.cs_n & ~s.bus_q.wr_n);
      next_s.rd_oe = ~s.bus_s2.cs_n & ~s.bus_s2.rd_n;
      // 16x tick divider
      next_s.tick = 1'b0;
      if ({s.dlm, s.dll} == 16'h0000) begin
         next_s.baud_cnt = 16'h0000;
      end else if (s.baud_cnt >= {s.dlm, s.dll} - 16'h0001) begin
         next_s.baud_cnt = 16'h0000;
         next_s.tick     = 1'b1;
      end else begin
         next_s.baud_cnt = s.baud_cnt + 16'h0001;
      end
      // host reads and their clearing effects
      if (rd_ev) begin
         if (s.line_format_control[LF_DLAB] && addr == OFF_DIV_LO) begin
            next_s.rd_data = s.dll;
         end else if (s.line_format_control[LF_DLAB] && addr == OFF_DIV_HI) begin
            next_s.rd_data = s.dlm;
         end else if (s.line_format_control[LF_DLAB] && addr == OFF_FEATURE) begin
            next_s.rd_data = s.efr;
         end else if (addr == OFF_HOLD) begin
            next_s.rd_data = s.rx_holding_reg;
            next_s.dr      = 1'b0;
         end else if (addr == OFF_IRQ_MASK) begin
            next_s.rd_data = s.irq_mask_reg;
         end else if (addr == OFF_IRQ_IDENT) begin
            next_s.rd_data = {4'h0, iid};
            if (ls_p) begin
               {next_s.oe, next_s.pe, next_s.fe, next_s.bi} = 4'h0;
            end else if (!rx_p && tx_p) begin
               next_s.thre_pend = 1'b0;
            end else if (!rx_p && ms_p) begin
               next_s.delta = 4'h0;
            end
         end else if (addr == OFF_LINE_FMT) begin
            next_s.rd_data = s.line_format_control;
         end else if (addr == OFF_MODEM_CTL) begin
            next_s.rd_data = s.modem_line_control;
         end else if (addr == OFF_LINE_STAT) begin
            next_s.rd_data = lsr_val;
            {next_s.oe, next_s.pe, next_s.fe, next_s.bi} = 4'h0;
         end else if (addr == OFF_MODEM_STAT) begin
            next_s.rd_data = {~eff_n, s.delta};
            next_s.delta   = 4'h0;
         end else begin
            next_s.rd_data = s.scratch_byte;
         end
      end
      // host writes
      if (wr_ev) begin
         if (s.line_format_control[LF_DLAB] && addr == OFF_DIV_LO) begin
            next_s.dll = s.bus_s2.data;
         end else if (s.line_format_control[LF_DLAB] && addr == OFF_DIV_HI) begin
            next_s.dlm = s.bus_s2.data;
         end else if (s.line_format_control[LF_DLAB] && addr == OFF_FEATURE) begin
            next_s.efr = s.bus_s2.data;
         end else if (addr == OFF_HOLD) begin
            buf_push         = 1'b1;
            next_s.thre_pend = 1'b0;
         end else if (addr == OFF_IRQ_MASK) begin
            next_s.irq_mask_reg = s.bus_s2.data & IRQ_MASK_MSK;
            if (s.bus_s2.data[IE_TX] && !s.irq_mask_reg[IE_TX] && !buf_valid) begin
               next_s.thre_pend = 1'b1;
            end
         end else if (addr == OFF_LINE_FMT) begin
            next_s.line_format_control = s.bus_s2.data;
         end else if (addr == OFF_MODEM_CTL) begin
            next_s.modem_line_control = s.bus_s2.data & MODEM_CTL_MSK;
         end else if (addr == OFF_SCRATCH) begin
            next_s.scratch_byte = s.bus_s2.data;
         end
      end
      // modem change flags, set after the read clear so an edge wins
      next_s.primed = 1'b1;
      next_s.mprev  = eff_n;
      next_s.delta  = next_s.delta | mchg;
      // holding register empty event
      next_s.empty_q = ~buf_valid;
      if (~buf_valid && !s.empty_q) begin
         next_s.thre_pend = 1'b1;
      end
      // transmitter
      case (s.tx_st)
         TX_IDLE: begin
            if (buf_valid && s.tick) begin
               buf_take     = 1'b1;
               next_s.tx_sh = 12'hfff;
               for (int i = 0; i < 8; i++) begin
                  if (4'(i) < wl) next_s.tx_sh[i+1] = buf_data[i];
               end
               if (pen) next_s.tx_sh[wl+4'h1] = par_bit(buf_data & msk, s.line_format_control);
               next_s.tx_sh[0] = 1'b0;
               nb = {1'b0, wl} + {4'h0, pen} + 5'h2 + {4'h0, s.line_format_control[LF_STOP]};
               next_s.tx_half  = (nb << 1) - {4'h0, s.line_format_control[LF_STOP] && wl == MIN_WORD};
               next_s.tx_sub   = 3'h0;
               next_s.tx_phase = 1'b0;
               next_s.tx_st    = TX_SEND;
            end
         end
         TX_SEND: begin
            if (s.tick) begin
               next_s.tx_sub = s.tx_sub + 3'h1;
               if (s.tx_sub == HALF_LAST) begin
                  next_s.tx_half  = s.tx_half - 5'h1;
                  next_s.tx_phase = ~s.tx_phase;
                  if (s.tx_phase) next_s.tx_sh = {1'b1, s.tx_sh[11:1]};
                  if (s.tx_half == 5'h1) begin
                     next_s.tx_sh = 12'hfff;
                     next_s.tx_st = TX_IDLE;
                  end
               end
            end
         end
         default: next_s.tx_st = TX_IDLE;
      endcase
      // line pin: mark in loop-back, space while breaking
      next_s.txd = s.modem_line_control[MC_LOOP] | (~s.line_format_control[LF_BREAK] & s.tx_sh[0]);
      // receiver input, looped from the transmitter when asked
      rxd = s.modem_line_control[MC_LOOP] ? (~s.line_format_control[LF_BREAK] & s.tx_sh[0]) : s.rx_s2;
      if (rxd) next_s.rx_armed = 1'b1;
      case (s.rx_st)
         RX_IDLE: begin
            if (s.tick && !rxd && s.rx_armed) begin
               next_s.rx_st    = RX_START;
               next_s.rx_cnt   = 4'h0;
               next_s.rx_armed = 1'b0;
            end
         end
         RX_START: begin
            if (s.tick) begin
               next_s.rx_cnt = s.rx_cnt + 4'h1;
               if (s.rx_cnt == START_CENTER) begin
                  next_s.rx_st   = rxd ? RX_IDLE : RX_DATA;
                  next_s.rx_cnt  = 4'h0;
                  next_s.rx_left = rx_n;
                  next_s.rx_zero = 1'b1;
               end
            end
         end
         RX_DATA: begin
            if (s.tick) begin
               next_s.rx_cnt = s.rx_cnt + 4'h1;
               if (s.rx_cnt == SAMPLE_LAST) begin
                  next_s.rx_sh   = {rxd, s.rx_sh[9:1]};
                  next_s.rx_zero = s.rx_zero & ~rxd;
                  next_s.rx_left = s.rx_left - 4'h1;
                  if (s.rx_left == 4'h1) begin
                     rx_done      = 1'b1;
                     next_s.rx_st = RX_IDLE;
                  end
               end
            end
         end
         default: next_s.rx_st = RX_IDLE;
      endcase
      // character complete: post data and status
      if (rx_done) begin
         fr      = {rxd, s.rx_sh[9:1]} >> (RX_SH_BITS - rx_n);
         rx_data = fr[7:0] & msk;
         if (next_s.dr) begin
            next_s.oe = 1'b1;
         end else begin
            next_s.rx_holding_reg = rx_data;
            next_s.dr  = 1'b1;
         end
         if (pen && fr[wl] != par_bit(rx_data, s.line_format_control)) next_s.pe = 1'b1;
         if (!rxd) next_s.fe = 1'b1;
         if (s.rx_zero && !rxd) next_s.bi = 1'b1;
      end
      // synchronous reset
      if (srst_in) begin
         next_s        = '0;
         next_s.bus_s1 = BUS_IDLE;
         next_s.bus_s2 = BUS_IDLE;
         next_s.bus_q  = BUS_IDLE;
         next_s.rx_s1  = 1'b1;
         next_s.rx_s2  = 1'b1;
         next_s.line_format_control    = LINE_FMT_RST;
         next_s.modem_line_control    = MODEM_CTL_RST;
         next_s.irq_mask_reg    = IRQ_MASK_RST;
         next_s.mdm_s1 = modem_in; // keep sampling so release shows no false change
         next_s.mdm_s2 = s.mdm_s1;
         next_s.empty_q = 1'b1;
         next_s.tx_sh  = 12'hfff;
         next_s.txd    = 1'b1;
         next_s.tx_st  = TX_IDLE;
         next_s.rx_st  = RX_IDLE;
      end
   end

   always_ff @(posedge clk_in) begin
      s <= next_s;
   end

   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   sequence s_full_done;
      s.dr && rx_done && !(rd_ev && addr == OFF_HOLD && !s.line_format_control[LF_DLAB]);
   endsequence
   sequence s_break_held;
      (s.line_format_control[LF_BREAK] && !s.modem_line_control[MC_LOOP])[*2];
   endsequence

   property p_overrun;
      s_full_done |=> s.oe && s.rx_holding_reg == $past(s.rx_holding_reg);
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun lost held byte");
   property p_ready;
      rx_done && !s.dr |=> s.dr && s.rx_holding_reg == $past(rx_data);
   endproperty
   a_ready: assert property (p_ready) else $error("received byte not posted");
   property p_break;
      s_break_held |-> !tx_out;
   endproperty
   a_break: assert property (p_break) else $error("break not on line");
   property p_dtr;
      wr_ev && addr == OFF_MODEM_CTL |=> dtr_n_out == !$past(s.bus_s2.data[MC_DTR]);
   endproperty
   a_dtr: assert property (p_dtr) else $error("terminal ready pin wrong");
   property p_rts;
      wr_ev && addr == OFF_MODEM_CTL |=> rts_n_out == !$past(s.bus_s2.data[MC_RTS]);
   endproperty
   a_rts: assert property (p_rts) else $error("request to send pin wrong");
   property p_int_oe;
      wr_ev && addr == OFF_MODEM_CTL |=> int_oe_out == $past(s.bus_s2.data[MC_INT_EN]);
   endproperty
   a_int_oe: assert property (p_int_oe) else $error("interrupt enable wrong");
   property p_lsr_clear;
      rd_ev && addr == OFF_LINE_STAT && !rx_done |=> !(s.oe || s.pe || s.fe || s.bi);
   endproperty
   a_lsr_clear: assert property (p_lsr_clear) else $error("error flags kept");
   property p_msr_clear;
      rd_ev && addr == OFF_MODEM_STAT && mchg == 4'h0 |=> s.delta == 4'h0;
   endproperty
   a_msr_clear: assert property (p_msr_clear) else $error("change flags kept");
   property p_ri_fall;
      s.primed && !s.delta[2] && s.mprev[2] && !eff_n[2] |=> !s.delta[2];
   endproperty
   a_ri_fall: assert property (p_ri_fall) else $error("ring flag on wrong edge");
   property p_scratch;
      wr_ev && addr == OFF_SCRATCH && !s.line_format_control[LF_DLAB] |=> s.scratch_byte == $past(s.bus_s2.data);
   endproperty
   a_scratch: assert property (p_scratch) else $error("scratch byte lost");
   property p_temt;
      lsr_val[6] |-> lsr_val[5] && !lsr_val[7];
   endproperty
   a_temt: assert property (p_temt) else $error("empty flags inconsistent");
   property p_prio;
      ls_p |-> iid == IRQ_ID_LS && int_out;
   endproperty
   a_prio: assert property (p_prio) else $error("line status not first");
   property p_divisor;
      wr_ev && s.line_format_control[LF_DLAB] && addr == OFF_DIV_LO |=> s.dll == $past(s.bus_s2.data);
   endproperty
   a_divisor: assert property (p_divisor) else $error("divisor write lost");

endmodule
`default_nettype wire

// file: modem_peer.sv
// Purpose: far-end modem model for the serial channel
// Assumes: divisor 1, one bit is 16 clocks
// Notes:   bench moves modem lines through modem_out
`timescale 1ns/1ps
`default_nettype none
module modem_peer
   import uart_lmc_pkg::*;
(
   // clock
   input  wire logic       clk_in,
   // serial and modem lines
   output var logic        rx_out,
   output var modem_pins_t modem_out
);
   // idle line high, modem lines inactive
   initial begin
      rx_out = 1'b1;
      modem_out = 4'hf;
   end
   // start, 8 data lsb first, optional parity, stop
   task automatic send(input logic [7:0] d, input logic pe, input logic p, input logic st);
      logic [10:0] f;
      f = {st, p, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         if (i != 9 || pe) begin
            @(posedge clk_in);
            #1 rx_out = f[i];
            repeat (15) @(posedge clk_in);
         end
      end
      @(posedge clk_in);
      #1 rx_out = 1'b1;
   endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Purpose: self-checking bench of the serial channel
// Assumes: divisor 1, one serial bit is 16 clocks
// Notes:   reads sample data_out while the strobe is low
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import uart_lmc_pkg::*;
();
   logic        clk_in = 1'b0;
   logic        srst_in = 1'b1;
   bus_pins_t   bus_in = BUS_IDLE;
   logic        rx;
   modem_pins_t modem;
   logic [7:0]  data_out, q, v;
   logic        data_oe_out, tx_ready_out, tx_out, dtr_n_out, rts_n_out, int_out, int_oe_out;
   int          error_cnt = 0;
   int          tests_run = 0;
   int          seed = 32'h4a5f72bc;

   uart_lmc_channel dut_u (.clk_in(clk_in), .srst_in(srst_in), .bus_in(bus_in), .data_out(data_out),
      .data_oe_out(data_oe_out), .tx_ready_out(tx_ready_out), .rx_in(rx), .tx_out(tx_out),
      .modem_in(modem), .dtr_n_out(dtr_n_out), .rts_n_out(rts_n_out), .int_out(int_out),
      .int_oe_out(int_oe_out));
   modem_peer peer_u (.clk_in(clk_in), .rx_out(rx), .modem_out(modem));

   // clock and hang guard
   initial begin
      forever #10 clk_in = !clk_in;
   end
   initial begin
      repeat (100000) @(posedge clk_in);
      error_cnt++;
      report_and_stop();
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one bus cycle, strobe held 5 clocks
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] wd);
      @(posedge clk_in);
      #1 bus_in = '{cs_n: 1'b0, rd_n: w, wr_n: !w, addr: a, data: wd};
      repeat (5) @(posedge clk_in);
      #1 q = data_out;
      chk({7'h0, data_oe_out}, {7'h0, !w});
      {bus_in.cs_n, bus_in.rd_n, bus_in.wr_n} = 3'b111;
      repeat (4) @(posedge clk_in);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk(q, e);
   endtask
   function automatic logic pbit(input logic [7:0] x, input logic [7:0] f);
      return f[5] ? !f[4] : (f[4] ? ^x : !(^x));
   endfunction
   // receive one random byte under format f
   task automatic rxc(input logic [7:0] f, input logic bad, input logic st, input logic [7:0] e);
      acc(1'b1, OFF_LINE_FMT, f);
      v = $random(seed);
      peer_u.send(v, f[3], pbit(v, f) ^ bad, st);
      repeat (4) @(posedge clk_in);
      rd(OFF_LINE_STAT, e);
      rd(OFF_HOLD, v);
   endtask
   task automatic report_and_stop;
      if (error_cnt == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (4) @(posedge clk_in);
      #1 srst_in = 1'b0;
      rd(OFF_LINE_STAT, 8'h60);
      rd(OFF_IRQ_IDENT, 8'h01);
      rd(OFF_MODEM_STAT, 8'h00);
      for (int i = 0; i < 6; i++) begin
         v = $random(seed);
         acc(1'b1, OFF_SCRATCH, v);
         rd(OFF_SCRATCH, v);
         acc(1'b1, OFF_MODEM_CTL, v & 8'h0f);
         chk({5'h0, dtr_n_out, rts_n_out, int_oe_out}, {5'h0, !v[0], !v[1], v[3]});
         acc(1'b1, OFF_MODEM_CTL, v | 8'h10);
         acc(1'b0, OFF_MODEM_STAT, 8'h00);
         chk({q[7:4], tx_out, 3'h0}, {v[3], v[2], v[0], v[1], 4'h8});
      end
      acc(1'b1, OFF_MODEM_CTL, 8'h08);
      acc(1'b0, OFF_MODEM_STAT, 8'h00);
      rd(OFF_MODEM_STAT, 8'h00);
      #1 peer_u.modem_out = 4'h0;
      repeat (4) @(posedge clk_in);
      rd(OFF_MODEM_STAT, 8'hfb);
      rd(OFF_MODEM_STAT, 8'hf0);
      acc(1'b1, OFF_IRQ_MASK, 8'h08);
      #1 peer_u.modem_out = 4'h4;
      repeat (4) @(posedge clk_in);
      chk({7'h0, int_out}, 8'h01);
      rd(OFF_IRQ_IDENT, 8'h00);
      rd(OFF_IRQ_IDENT, 8'h01);
      rd(OFF_MODEM_STAT, 8'hb0);
      acc(1'b1, OFF_IRQ_MASK, 8'h00);
      acc(1'b1, OFF_LINE_FMT, 8'h80);
      acc(1'b1, OFF_DIV_LO, 8'h01);
      acc(1'b1, OFF_DIV_HI, 8'h00);
      rd(OFF_DIV_LO, 8'h01);
      rxc(8'h03, 1'b0, 1'b1, 8'h61);
      rxc(8'h0b, 1'b1, 1'b1, 8'h65);
      rxc(8'h1b, 1'b0, 1'b1, 8'h61);
      rxc(8'h2b, 1'b1, 1'b1, 8'h65);
      rxc(8'h3b, 1'b0, 1'b1, 8'h61);
      rxc(8'h03, 1'b0, 1'b0, 8'h69);
      peer_u.send(8'h00, 1'b0, 1'b0, 1'b0);
      rd(OFF_LINE_STAT, 8'h79);
      rd(OFF_HOLD, 8'h00);
      peer_u.send(8'h5a, 1'b0, 1'b0, 1'b1);
      peer_u.send(8'ha5, 1'b0, 1'b0, 1'b1);
      repeat (4) @(posedge clk_in);
      rd(OFF_LINE_STAT, 8'h63);
      rd(OFF_HOLD, 8'h5a);
      rd(OFF_LINE_STAT, 8'h60);
      acc(1'b1, OFF_HOLD, v);
      rd(OFF_LINE_STAT, 8'h20);
      repeat (200) @(posedge clk_in);
      rd(OFF_LINE_STAT, 8'h60);
      acc(1'b1, OFF_LINE_FMT, 8'h43);
      chk({7'h0, tx_out}, 8'h00);
      acc(1'b1, OFF_LINE_FMT, 8'h03);
      chk({7'h0, tx_out}, 8'h01);
      // loop-back transfer, transmit-empty interrupt, full buffer
      acc(1'b1, OFF_MODEM_CTL, 8'h10);
      acc(1'b1, OFF_LINE_FMT, 8'h2b);
      acc(1'b1, OFF_HOLD, v);
      repeat (200) @(posedge clk_in);
      rd(OFF_LINE_STAT, 8'h61);
      rd(OFF_HOLD, v);
      acc(1'b1, OFF_IRQ_MASK, 8'h02);
      chk({7'h0, int_out}, 8'h01);
      rd(OFF_IRQ_IDENT, 8'h02);
      rd(OFF_IRQ_IDENT, 8'h01);
      acc(1'b1, OFF_LINE_FMT, 8'h80);
      acc(1'b1, OFF_DIV_LO, 8'h00);
      acc(1'b1, OFF_LINE_FMT, 8'h03);
      acc(1'b1, OFF_HOLD, v);
      acc(1'b1, OFF_HOLD, v);
      chk({7'h0, tx_ready_out}, 8'h00);
      rd(OFF_LINE_STAT, 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
